// file: shared/admit_pkg.sv
/*
 * Constants, register map and encodings of the frame admission block.
 * Assumes a 100 MHz core clock shared by the APB slave and ingress logic.
 */
package admit_pkg;

    localparam int N_PORTS = 3;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CTRL0 = 10'h330;
    localparam logic [9:0] IDX_CTRL1 = 10'h331;
    localparam logic [9:0] IDX_CTRL2 = 10'h332;
    localparam logic [9:0] IDX_CTRL3 = 10'h333;
    localparam logic [9:0] IDX_STATUS = 10'h337;

    localparam logic [7:0] RST_CTRL0 = 8'h0E;
    localparam logic [7:0] RST_CTRL1 = 8'hF0;
    localparam logic [7:0] RST_CTRL2 = 8'h00;
    localparam logic [7:0] RST_CTRL3 = 8'h4A;

    // Control 0 fields
    localparam int B0_ALT_BACKOFF = 7;
    // Control 1 fields
    localparam int B1_MC_EXCL = 6;
    localparam int B1_BP_CSENSE = 5;
    localparam int B1_FAIR = 4;
    localparam int B1_NO_COLL_DROP = 3;
    localparam int B1_JUMBO = 2;
    localparam int B1_OVERSIZE_DIS = 1;
    localparam int B1_PASS_SHORT = 0;
    // Control 2 fields
    localparam int B2_NULL_VID = 3;
    localparam int B2_RATE_HI_MSB = 2;

    ////////////////////////////////////////////////////////////////////////
    // Frame size limits in bytes
    localparam logic [13:0] LEN_MIN_STD = 14'h0040;
    localparam logic [13:0] LEN_MIN_SHORT = 14'h0020;
    localparam logic [13:0] LEN_MAX_UNTAG = 14'h05EE;
    localparam logic [13:0] LEN_MAX_TAG = 14'h05F2;
    localparam logic [13:0] LEN_MAX_NOCHK = 14'h07D0;
    localparam logic [13:0] LEN_MAX_JUMBO = 14'h2328;

    localparam logic [4:0] COLL_LIMIT = 5'h10;
    localparam int STORM_UNIT_SHIFT = 6;

    ////////////////////////////////////////////////////////////////////////
    // Storm measurement periods
    localparam int CLK_MHZ = 100;
    localparam int PERIOD_1000_MS = 5;
    localparam int PERIOD_100_MS = 50;
    localparam int PERIOD_10_MS = 500;
    localparam int PERIOD_1000_CYC = PERIOD_1000_MS * 1000 * CLK_MHZ;
    localparam int PERIOD_100_CYC = PERIOD_100_MS * 1000 * CLK_MHZ;
    localparam int PERIOD_10_CYC = PERIOD_10_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {
        SPEED_10 = 2'b00,
        SPEED_100 = 2'b01,
        SPEED_1000 = 2'b10
    } speed_t;

    typedef enum logic [2:0] {
        RSN_NONE = 3'b000,
        RSN_SHORT = 3'b001,
        RSN_LONG = 3'b010,
        RSN_STORM = 3'b011,
        RSN_FAIR = 3'b100,
        RSN_PORT = 3'b101
    } reason_t;

endpackage

// file: hw/storm_meter.sv
/*
 * Per-port storm byte meter: period timer and byte count against a budget.
 * Assumes speed, budget and charge come from logic on the same clock.
 */
module storm_meter
    import admit_pkg::*;
#(
    parameter int PERIOD_10 = admit_pkg::PERIOD_10_CYC,
    parameter int PERIOD_100 = admit_pkg::PERIOD_100_CYC,
    parameter int PERIOD_1000 = admit_pkg::PERIOD_1000_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] speed,
    input wire logic [16:0] budget,
    input wire logic charge,
    input wire logic [13:0] charge_len,
    output logic exhausted
);

    logic [25:0] cnt_q, cnt_d;
    logic [17:0] used_q, used_d;
    logic [25:0] lim;
    logic wrap;
    logic [18:0] sum;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        unique case (speed)
            SPEED_1000: lim = 26'(PERIOD_1000 - 1);
            SPEED_100: lim = 26'(PERIOD_100 - 1);
            default: lim = 26'(PERIOD_10 - 1);
        endcase
        // Compare with >= so a speed rise never strands the timer
        wrap = cnt_q >= lim;
        cnt_d = wrap ? 26'h0000000 : cnt_q + 26'h0000001;
        sum = {1'b0, used_q} + {5'h00, charge_len};
        if (wrap)
            used_d = charge ? {4'h0, charge_len} : 18'h00000;
        else if (charge)
            used_d = sum[18] ? 18'h3FFFF : sum[17:0];
        else
            used_d = used_q;
        exhausted = used_q >= {1'b0, budget};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q <= 26'h0000000;
            used_q <= 18'h00000;
        end
        else
        begin
            cnt_q <= cnt_d;
            used_q <= used_d;
        end
    end

endmodule // storm_meter

// file: hw/frame_admission.sv
/*
 * Switch MAC frame admission: APB control registers, per-frame size,
 * storm and fair-mode decision, null VID replacement, collision policy.
 * Assumes frame descriptors, collision events and port speeds come from
 * switch logic on pclk; one frame descriptor per cycle at most.
 */
// The APB slave port was chosen for this implementation.
module frame_admission
    import admit_pkg::*;
#(
    parameter int PERIOD_10 = admit_pkg::PERIOD_10_CYC,
    parameter int PERIOD_100 = admit_pkg::PERIOD_100_CYC,
    parameter int PERIOD_1000 = admit_pkg::PERIOD_1000_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] port_speed,
    input wire logic [35:0] port_pvid,
    input wire logic [13:0] jumbo_limit,
    input wire logic frm_valid,
    input wire logic [1:0] frm_port,
    input wire logic [13:0] frm_len,
    input wire logic frm_tagged,
    input wire logic frm_bcast,
    input wire logic frm_mcast,
    input wire logic [11:0] frm_vid,
    input wire logic frm_src_fc,
    input wire logic frm_egr_congested,
    output logic res_valid,
    output logic res_accept,
    output logic [2:0] res_reason,
    output logic [11:0] res_vid,
    output logic res_pause,
    input wire logic coll_valid,
    input wire logic [4:0] coll_count,
    output logic coll_retry,
    output logic coll_discard,
    output logic bp_carrier_sense,
    output logic alt_backoff
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    logic [7:0] ctrl0_q, ctrl0_d;
    logic [7:0] ctrl1_q, ctrl1_d;
    logic [7:0] ctrl2_q, ctrl2_d;
    logic [7:0] ctrl3_q, ctrl3_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic [N_PORTS-1:0] exhausted;
    logic [9:0] idx;
    logic mapped;
    logic wr_en;

    function automatic logic idx_mapped(input logic [9:0] i);
        idx_mapped = (i == IDX_CTRL0) || (i == IDX_CTRL1) ||
            (i == IDX_CTRL2) || (i == IDX_CTRL3) || (i == IDX_STATUS);
    endfunction

    always_comb
    begin
        idx = paddr[11:2];
        mapped = idx_mapped(idx) && (paddr[1:0] == 2'b00);
        // Status is read only; a write there is taken and ignored
        wr_en = psel && penable && pwrite && pstrb[0] && mapped;
        ctrl0_d = ctrl0_q;
        ctrl1_d = ctrl1_q;
        ctrl2_d = ctrl2_q;
        ctrl3_d = ctrl3_q;
        if (wr_en)
        begin
            unique case (idx)
                IDX_CTRL0: ctrl0_d = pwdata[7:0];
                IDX_CTRL1: ctrl1_d = pwdata[7:0];
                IDX_CTRL2: ctrl2_d = pwdata[7:0];
                IDX_CTRL3: ctrl3_d = pwdata[7:0];
                default: ;
            endcase
        end
        // Read data captured in setup so it leaves a flop with no wait state
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (psel && !penable)
        begin
            pslverr_d = !mapped;
            unique case (idx)
                IDX_CTRL0: prdata_d = {24'h000000, ctrl0_q};
                IDX_CTRL1: prdata_d = {24'h000000, ctrl1_q};
                IDX_CTRL2: prdata_d = {24'h000000, ctrl2_q};
                IDX_CTRL3: prdata_d = {24'h000000, ctrl3_q};
                IDX_STATUS: prdata_d = {29'h00000000, exhausted};
                default: prdata_d = 32'h00000000;
            endcase
            if (!mapped || pwrite)
                prdata_d = 32'h00000000;
        end
        pready = 1'b1;
        prdata = prdata_q;
        pslverr = pslverr_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_q <= RST_CTRL0;
            ctrl1_q <= RST_CTRL1;
            ctrl2_q <= RST_CTRL2;
            ctrl3_q <= RST_CTRL3;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            ctrl0_q <= ctrl0_d;
            ctrl1_q <= ctrl1_d;
            ctrl2_q <= ctrl2_d;
            ctrl3_q <= ctrl3_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Storm meters, one per ingress port

    logic [10:0] storm_rate;
    logic [16:0] storm_budget;
    logic [N_PORTS-1:0] charge;

    always_comb
    begin
        storm_rate = {ctrl2_q[B2_RATE_HI_MSB:0], ctrl3_q};
        storm_budget = {storm_rate, 6'h00};
    end

    for (genvar p = 0; p < N_PORTS; p++)
    begin : g_meter
        storm_meter #(
            .PERIOD_10(PERIOD_10),
            .PERIOD_100(PERIOD_100),
            .PERIOD_1000(PERIOD_1000)
        ) u_meter (
            .pclk(pclk),
            .presetn(presetn),
            .speed(port_speed[2*p +: 2]),
            .budget(storm_budget),
            .charge(charge[p]),
            .charge_len(frm_len),
            .exhausted(exhausted[p])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame decision

    logic res_valid_q, res_valid_d;
    logic res_accept_q, res_accept_d;
    logic [2:0] res_reason_q, res_reason_d;
    logic [11:0] res_vid_q, res_vid_d;
    logic res_pause_q, res_pause_d;
    logic [13:0] max_len;
    logic [13:0] min_len;
    logic [13:0] jumbo_cap;
    logic port_ok;
    logic storm_class;
    logic storm_hit;
    logic fair_drop;
    logic [11:0] pvid;
    reason_t reason;

    function automatic logic [11:0] pick_pvid(input logic [35:0] all,
                                              input logic [1:0] p);
        pick_pvid = all[12*p +: 12];
    endfunction

    always_comb
    begin
        jumbo_cap = (jumbo_limit > LEN_MAX_JUMBO) ? LEN_MAX_JUMBO
                                                  : jumbo_limit;
        // Jumbo first: it masks the oversize-check disable bit
        if (ctrl1_q[B1_JUMBO])
            max_len = jumbo_cap;
        else if (ctrl1_q[B1_OVERSIZE_DIS])
            max_len = LEN_MAX_NOCHK;
        else
            max_len = frm_tagged ? LEN_MAX_TAG : LEN_MAX_UNTAG;
        min_len = ctrl1_q[B1_PASS_SHORT] ? LEN_MIN_SHORT
                                         : LEN_MIN_STD;
        port_ok = frm_port < 2'(N_PORTS);
        storm_class = frm_bcast ||
            (frm_mcast && !ctrl1_q[B1_MC_EXCL]);
        storm_hit = storm_class && port_ok && exhausted[frm_port];
        // Only a non-flow-controlled source is dropped, and only when fair
        fair_drop = frm_egr_congested && !frm_src_fc &&
            ctrl1_q[B1_FAIR];
        if (!port_ok)
            reason = RSN_PORT;
        else if (frm_len < min_len)
            reason = RSN_SHORT;
        else if (frm_len > max_len)
            reason = RSN_LONG;
        else if (fair_drop)
            reason = RSN_FAIR;
        else if (storm_hit)
            reason = RSN_STORM;
        else
            reason = RSN_NONE;
        pvid = pick_pvid(port_pvid, port_ok ? frm_port : 2'b00);
        charge = '0;
        if (frm_valid && storm_class && reason == RSN_NONE)
            charge[frm_port] = 1'b1;

        res_valid_d = frm_valid;
        res_accept_d = res_accept_q;
        res_reason_d = res_reason_q;
        res_vid_d = res_vid_q;
        res_pause_d = 1'b0;
        if (frm_valid)
        begin
            res_accept_d = reason == RSN_NONE;
            res_reason_d = reason;
            if (ctrl2_q[B2_NULL_VID] && frm_vid == 12'h000)
                res_vid_d = pvid;
            else
                res_vid_d = frm_vid;
            // Pause goes to the flow-controlled source in either mode
            res_pause_d = frm_egr_congested && frm_src_fc;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_valid_q <= 1'b0;
            res_accept_q <= 1'b0;
            res_reason_q <= RSN_NONE;
            res_vid_q <= 12'h000;
            res_pause_q <= 1'b0;
        end
        else
        begin
            res_valid_q <= res_valid_d;
            res_accept_q <= res_accept_d;
            res_reason_q <= res_reason_d;
            res_vid_q <= res_vid_d;
            res_pause_q <= res_pause_d;
        end
    end

    always_comb
    begin
        res_valid = res_valid_q;
        res_accept = res_accept_q;
        res_reason = res_reason_q;
        res_vid = res_vid_q;
        res_pause = res_pause_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Collision policy and half-duplex mode levels

    logic coll_retry_q, coll_retry_d;
    logic coll_discard_q, coll_discard_d;
    logic coll_excess;

    always_comb
    begin
        coll_excess = coll_count >= COLL_LIMIT;
        coll_discard_d = coll_valid && coll_excess &&
            !ctrl1_q[B1_NO_COLL_DROP];
        coll_retry_d = coll_valid && !(coll_excess &&
            !ctrl1_q[B1_NO_COLL_DROP]);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            coll_retry_q <= 1'b0;
            coll_discard_q <= 1'b0;
        end
        else
        begin
            coll_retry_q <= coll_retry_d;
            coll_discard_q <= coll_discard_d;
        end
    end

    always_comb
    begin
        coll_retry = coll_retry_q;
        coll_discard = coll_discard_q;
        bp_carrier_sense = ctrl1_q[B1_BP_CSENSE];
        // Only meaningful to half-duplex MACs; full duplex ignores it
        alt_backoff = ctrl0_q[B0_ALT_BACKOFF];
    end

endmodule // frame_admission

// file: verif/admit_props.sv
/* Port checker for frame_admission.
   Assumes it is bound to frame_admission and sees only its ports. */
module admit_props
    import admit_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic frm_valid,
    input wire logic [1:0] frm_port,
    input wire logic [13:0] frm_len,
    input wire logic frm_tagged,
    input wire logic frm_src_fc,
    input wire logic frm_egr_congested,
    input wire logic res_valid,
    input wire logic [2:0] res_reason,
    input wire logic res_pause,
    input wire logic coll_valid,
    input wire logic [4:0] coll_count,
    input wire logic coll_retry,
    input wire logic coll_discard,
    input wire logic bp_carrier_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] c1_q;
    logic [7:0] c1_d;
    // Mirror of control 1, since the policy bits are not at the ports
    always_comb
    begin
        c1_d = c1_q;
        if (psel && penable && pwrite && pstrb[0] &&
            paddr == {IDX_CTRL1, 2'b00})
            c1_d = pwdata[7:0];
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            c1_q <= RST_CTRL1;
        else
            c1_q <= c1_d;
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_frm;
        frm_valid && frm_port != 2'h3 && frm_len >= LEN_MIN_STD;
    endsequence
    AST_COLL_DROP: assert property (coll_valid && coll_count >= 5'h10
        && !c1_q[3] |=> coll_discard && !coll_retry) else $error("no discard");
    AST_COLL_KEEP: assert property (coll_valid && c1_q[3]
        |=> coll_retry && !coll_discard) else $error("no retry");
    AST_BP_MODE: assert property (bp_carrier_sense == c1_q[5])
        else $error("back pressure mode wrong");
    AST_SHORT_DROP: assert property (frm_valid && frm_port != 2'h3
        && !c1_q[0] && frm_len < LEN_MIN_STD |=> res_reason == RSN_SHORT)
        else $error("short frame kept");
    AST_SHORT_PASS: assert property (frm_valid && c1_q[0]
        && frm_len >= LEN_MIN_SHORT |=> res_reason != RSN_SHORT)
        else $error("short frame dropped");
    AST_STD_LONG: assert property (s_frm ##0 (c1_q[2:1] == 2'b00
        && frm_len > (frm_tagged ? LEN_MAX_TAG : LEN_MAX_UNTAG))
        |=> res_reason == RSN_LONG) else $error("long frame kept");
    AST_NOCHK: assert property (s_frm ##0 (c1_q[2:1] == 2'b01
        && frm_len > LEN_MAX_TAG) |=> (res_reason == RSN_LONG)
        == ($past(frm_len) > LEN_MAX_NOCHK)) else $error("2000 limit");
    AST_FAIR_OFF: assert property (s_frm ##0 (!c1_q[4]
        && frm_egr_congested && !frm_src_fc) |=> res_reason != RSN_FAIR)
        else $error("fair drop while off");
    AST_PAUSE: assert property (frm_valid |=> res_valid
        && res_pause == ($past(frm_egr_congested) && $past(frm_src_fc)))
        else $error("result or pause wrong");
endmodule // admit_props

bind frame_admission admit_props admit_props_i (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pstrb, .frm_valid, .frm_port,
    .frm_len, .frm_tagged, .frm_src_fc, .frm_egr_congested, .res_valid,
    .res_reason, .res_pause, .coll_valid, .coll_count, .coll_retry,
    .coll_discard, .bp_carrier_sense);

// file: verif/coll_source.sv
/* Link partner model: reports collision counts of frames in flight.
   Assumes kick is driven just after a pclk rising edge. */
module coll_source
(
    input wire logic pclk,
    input wire logic kick,
    input wire logic [4:0] kick_count,
    output logic coll_valid = 1'b0,
    output logic [4:0] coll_count = 5'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    // Count means nothing outside the pulse, so it keeps toggling
    always @(posedge pclk)
    begin
        coll_valid <= kick;
        coll_count <= kick ? kick_count : ~coll_count;
    end
endmodule // coll_source

// file: verif/tb.sv
/* Self-checking bench for frame_admission.
   Assumes admit_pkg, the checker and coll_source are compiled first. */
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import admit_pkg::*;
    localparam logic [35:0] PVID = 36'hABC123456;
    localparam int P_FAST = 150, P_MID = 300, P_SLOW = 3000;
    logic [5:0] port_speed = 6'h06;
    int gap;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, kick = 0;
    logic [11:0] paddr = 0, frm_vid = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0] pstrb = 4'hF;
    logic [13:0] jumbo_limit = 14'h2328, frm_len = 0;
    logic frm_valid = 0, frm_tagged = 0, frm_bcast = 0, frm_mcast = 0;
    logic frm_src_fc = 0, frm_egr_congested = 0, pready, pslverr;
    logic [1:0] frm_port = 0;
    logic [4:0] kick_count = 0, coll_count;
    logic res_valid, res_accept, res_pause, coll_valid, coll_retry;
    logic coll_discard, bp_carrier_sense, alt_backoff;
    logic [2:0] res_reason;
    logic [11:0] res_vid;
    logic [7:0] c1 = 8'hF0, c2 = 0;
    logic [32:0] q_rd[$];
    logic [17:0] q_f[$], e_f;
    logic [1:0] q_c[$];
    logic [4:0] cnt [3] = '{5'h0F, 5'h10, 5'h1F};
    logic [13:0] lens [8] = '{14'h001F, 14'h0020, 14'h003F, 14'h05EE,
        14'h05EF, 14'h05F3, 14'h07D1, 14'h2329};
    int failures = 0, n_checks = 0, cyc = 0, last_acc, n_acc, n_drop;
    always #5 pclk = ~pclk;
    frame_admission #(.PERIOD_10(P_SLOW), .PERIOD_100(P_MID),
        .PERIOD_1000(P_FAST)) frame_admission_i (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .port_speed, .port_pvid(PVID), .jumbo_limit, .frm_valid,
        .frm_port, .frm_len, .frm_tagged, .frm_bcast, .frm_mcast, .frm_vid,
        .frm_src_fc, .frm_egr_congested, .res_valid, .res_accept,
        .res_reason, .res_vid, .res_pause, .coll_valid, .coll_count,
        .coll_retry, .coll_discard, .bp_carrier_sense, .alt_backoff);
    coll_source coll_source_i (.pclk, .kick, .kick_count, .coll_valid,
        .coll_count);
    ////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [32:0] e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            q_rd.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (w && a == 12'hCC4)
            c1 = d[7:0];
        if (w && a == 12'hCC8)
            c2 = d[7:0];
        @(posedge pclk);
    endtask
    task frm(input logic [1:0] p, input logic [13:0] l, input logic t,
        input logic bc, input logic mc, input logic [11:0] v,
        input logic cg, input logic fc, input logic [17:0] e);
        frm_valid <= 1'b1;
        {frm_port, frm_len, frm_tagged, frm_bcast, frm_mcast} <= {p, l, t, bc, mc};
        {frm_vid, frm_egr_congested, frm_src_fc} <= {v, cg, fc};
        q_f.push_back(e);
        @(posedge pclk);
    endtask
    task idle;
        frm_valid <= 1'b0;
        frm_len <= ~frm_len;
        frm_vid <= ~frm_vid;
        repeat (3) @(posedge pclk);
    endtask
    function logic [17:0] expf(logic [1:0] p, logic [13:0] l, logic t,
        logic [11:0] v, logic cg, logic fc);
        logic [13:0] mn, mx;
        logic [2:0] r;
        mn = c1[0] ? LEN_MIN_SHORT : LEN_MIN_STD;
        mx = c1[2] ? (jumbo_limit > LEN_MAX_JUMBO ? LEN_MAX_JUMBO : jumbo_limit)
            : c1[1] ? LEN_MAX_NOCHK : t ? LEN_MAX_TAG : LEN_MAX_UNTAG;
        r = p == 2'h3 ? RSN_PORT : l < mn ? RSN_SHORT : l > mx ? RSN_LONG
            : (cg && !fc && c1[4]) ? RSN_FAIR : RSN_NONE;
        return {1'b0, cg && fc, r == RSN_NONE, r, (c2[3] && v == 12'h000)
            ? PVID[12 * (p == 2'h3 ? 0 : p) +: 12] : v};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    always @(posedge pclk)
    begin
        cyc++;
        if (psel && penable && pready && !pwrite)
            `CHK("read", q_rd.pop_front(), {pslverr, prdata})
        if (coll_retry || coll_discard)
            `CHK("coll", q_c.pop_front(), {coll_discard, coll_retry})
        if (res_valid === 1'b1)
        begin
            e_f = q_f.size() > 0 ? q_f.pop_front() : 18'h1FFFF;
            if (!e_f[17])
                `CHK("result", e_f[16:0], {res_pause, res_accept, res_reason, res_vid})
            else if (res_accept === 1'b1)
            begin
                n_acc++;
                if (n_acc > 2)
                    `CHK("gap", gap, cyc - last_acc)
                last_acc = cyc;
            end
            else
            begin
                n_drop++;
                `CHK("storm", RSN_STORM, res_reason)
            end
        end
        // Last in the process, so nothing runs after the finish
        if (cyc == 20000)
        begin
            failures++;
            conclude();
        end
    end
    initial
    begin
        void'($urandom(32'h508045F5));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'hCC0, 0, 33'h00000000E);
        apb(0, 12'hCC4, 0, 33'h0000000F0);
        apb(0, 12'hCC8, 0, 33'h000000000);
        apb(0, 12'hCCC, 0, 33'h00000004A);
        apb(0, 12'hCD0, 0, 33'h100000000);
        apb(0, 12'hCC5, 0, 33'h100000000);
        apb(0, 12'hCDC, 0, 33'h000000000);
        // Lane 0 strobe low: the write must leave the register alone
        pstrb <= 4'hE;
        apb(1, 12'hCC0, 32'h000000FF, 0);
        pstrb <= 4'hF;
        apb(0, 12'hCC0, 0, 33'h00000000E);
        `CHK("bp", 1'b1, bp_carrier_sense)
        $display("test registers done");
        for (int k = 0; k < 2; k++)
        begin
            apb(1, 12'hCC0, {24'h0, k[0], 7'h0E}, 0);
            apb(1, 12'hCC4, {28'h0, k[0], 3'h0}, 0);
            `CHK("alt", k[0], alt_backoff)
            `CHK("bp", 1'b0, bp_carrier_sense)
            foreach (cnt[j])
            begin
                kick <= 1'b1;
                kick_count <= cnt[j];
                q_c.push_back(cnt[j] >= COLL_LIMIT && !k[0] ? 2'b10 : 2'b01);
                @(posedge pclk);
            end
            kick <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        $display("test collisions done");
        for (int n = 0; n < 300; n++)
        begin
            if (n % 30 == 0)
            begin
                idle();
                jumbo_limit <= $urandom_range(1) ? 14'h0640 : 14'h3FFF;
                apb(1, 12'hCC4, $urandom & 32'h1F, 0);
                apb(1, 12'hCC8, $urandom & 32'h8, 0);
            end
            frm($urandom, lens[$urandom_range(7)] + $urandom_range(1), $urandom,
                0, 0, $urandom_range(1) ? 12'h000 : $urandom, $urandom, $urandom,
                18'h0);
            q_f[q_f.size() - 1] = expf(frm_port, frm_len, frm_tagged, frm_vid,
                frm_egr_congested, frm_src_fc);
        end
        idle();
        $display("test sizes done");
        apb(1, 12'hCC4, 32'h40, 0);
        apb(1, 12'hCC8, 0, 0);
        apb(1, 12'hCCC, 32'h01, 0);
        repeat (4) frm(0, 14'h0040, 0, 0, 1, 12'h001, 0, 0, 18'h08001);
        for (int ph = 0; ph < 2; ph++)
        begin
            port_speed <= ph ? 6'h05 : 6'h06;
            gap = ph ? P_MID : P_FAST;
            idle();
            if (ph)
                apb(1, 12'hCC4, 0, 0);
            {last_acc, n_acc, n_drop} = 0;
            repeat (950) frm(0, 14'h0040, 0, !ph, ph, 12'h001, 0, 0, 18'h20000);
            idle();
            `CHK("accepts", 1'b1, n_acc >= 3)
            `CHK("drops", 1'b1, n_drop > 0)
        end
        apb(1, 12'hCCC, 0, 0);
        repeat (3) frm(2, 14'h0040, 0, 1, 0, 12'h005, 0, 0, 18'h03005);
        idle();
        apb(0, 12'hCDC, 0, 33'h000000007);
        `CHK("pending", 0, q_rd.size() + q_f.size() + q_c.size())
        $display("test storm done");
        conclude();
    end
endmodule // tb
